// *** hw/baseband_gain_and_output_formatter.sv ***
// Purpose: gain chain, decimating filter and output formatter for an I/Q channel
// Assumes: inputs synchronous to clk_sys_i; pipeline stalls while the fifo is full
// Notes:   sample_fifo sits between the compensation output and the formatter
`timescale 1ns/1ps
`include "bgof_defs.svh"

module sample_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             clk_sys_i,   // system clock
    input  wire logic             rst_n_i,     // async reset, active low
    input  wire logic             in_valid_i,  // write request
    output      logic             in_ready_o,  // room available
    input  wire logic [WIDTH-1:0] in_data_i,   // write data
    output      logic             out_valid_o, // data available
    input  wire logic             out_ready_i, // read request
    output      logic [WIDTH-1:0] out_data_o   // head entry
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              do_wr = in_valid_i && in_ready_o;
    wire              do_rd = out_valid_o && out_ready_i;

    // depth must be a power of two: pointers wrap on their extra bit
    assign in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) wr_ptr <= wr_ptr + 1'b1;
            if (do_rd) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (do_wr) mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
endmodule : sample_fifo

// Operation
// - parallel or bit-serial output selected by configuration
// - two's complement or offset binary output coding
// - parallel I/Q together, strobe on first cycle
// - separate enables float each output bus
// - strobe polarity selectable high or low
// - simultaneous serial: I and Q on lowest lines
// - interleaved: I then Q, 16-bit words, zero pad
// - interleaved I word carries a one in lsb
// - serial clock on top pin, divide 2/4/8
// - divide by one holds serial clock pin high
// - strobe one serial period before first bit
// - interleaved mode strobes each 16-bit word
// - serial bit order msb or lsb first
// - mixer multiplies by sinusoid, rounds to 12 bits
// - fixed attenuation offsets worst filter gain
// - agc gain from unity to 1.9375 times 2^7
// - shifter gain 2^0 up to 2^63
// - filter gain rate^order, order 1 or 3
// - filter result rounded, saturated to 11 bits
// - compensation gain 1.0, 0.65 or 0.77
// - compensation result rounded, saturated to 10 bits
module baseband_gain_and_output_formatter
    import bgof_pkg::*;
(
    input  wire logic                   clk_sys_i,                // system clock, 100 MHz
    input  wire logic                   rst_n_i,                  // async reset, active low
    input  wire logic                   in_valid_i,               // input sample valid
    output      logic                   in_ready_o,               // low while the pipeline stalls
    input  wire logic [`SAMPLE_W-1:0]   in_i_i,                   // in-phase input, signed fraction
    input  wire logic [`SAMPLE_W-1:0]   in_q_i,                   // quadrature input, zero for real
    input  wire logic [`SAMPLE_W-1:0]   lo_cos_i,                 // local oscillator cosine
    input  wire logic [`SAMPLE_W-1:0]   lo_sin_i,                 // local oscillator sine
    input  wire logic [`AGC_FRAC_W-1:0] agc_frac_i,               // agc mantissa fraction
    input  wire logic [`AGC_EXP_W-1:0]  agc_exp_i,                // agc exponent 0..7
    input  wire logic [`SHIFT_W-1:0]    shift_i,                  // shifter exponent 0..63
    input  wire filt_mode_e             filt_mode_i,              // decimating filter mode
    input  wire logic [`DEC_W-1:0]      dec_div_i,                // decimation divisor minus one
    input  wire comp_mode_e             comp_mode_i,              // compensation shape
    input  wire fmt_cfg_s               cfg_i,                    // output format setup
    input  wire logic                   inphase_bus_enable_i,     // drive in-phase bus when high
    input  wire logic                   quadrature_bus_enable_i,  // drive quadrature bus when high
    output      logic [`SAMPLE_W-1:0]   inphase_out_bus_o,        // in-phase bus / serial pins
    output      logic [`SAMPLE_W-1:0]   inphase_out_bus_oe_o,     // in-phase bus output enables
    output      logic [`SAMPLE_W-1:0]   quadrature_out_bus_o,     // quadrature bus / serial pin
    output      logic [`SAMPLE_W-1:0]   quadrature_out_bus_oe_o,  // quadrature bus output enables
    output      logic                   output_valid_strobe_o     // word strobe, programmable level
);
    localparam int NLANE = 2;

    logic                  fifo_in_ready;
    logic                  mix_v;
    logic                  scl_v;
    logic [`DEC_W-1:0]     dcnt;
    wire                   adv      = fifo_in_ready;
    wire                   dump_now = (dcnt == '0);
    wire                   push     = scl_v && dump_now;
    wire                   sample   = adv && scl_v;

    assign in_ready_o = fifo_in_ready;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mix_v <= 1'b0;
            scl_v <= 1'b0;
            dcnt  <= '0;
        end else if (adv) begin
            mix_v <= in_valid_i;
            scl_v <= mix_v;
            if (scl_v) dcnt <= dump_now ? dec_div_i : dcnt - 1'b1;
        end
    end

    wire signed [2*`SAMPLE_W-1:0] p_ic = $signed(in_i_i) * $signed(lo_cos_i);
    wire signed [2*`SAMPLE_W-1:0] p_qs = $signed(in_q_i) * $signed(lo_sin_i);
    wire signed [2*`SAMPLE_W-1:0] p_is = $signed(in_i_i) * $signed(lo_sin_i);
    wire signed [2*`SAMPLE_W-1:0] p_qc = $signed(in_q_i) * $signed(lo_cos_i);
    logic signed [`MIX_PROD_W-1:0] mix_sum [NLANE];
    assign mix_sum[0] = `MIX_PROD_W'(p_ic) - `MIX_PROD_W'(p_qs);
    assign mix_sum[1] = `MIX_PROD_W'(p_is) + `MIX_PROD_W'(p_qc);

    wire [`GAIN_SUM_W-1:0] gain_exp = {4'h0, agc_exp_i} + {1'b0, shift_i};
    wire [`AGC_FRAC_W:0]   agc_mant = {1'b1, agc_frac_i};

    logic [`COEF_W-1:0] comp_coef;
    assign comp_coef = (comp_mode_i == COMP_SINC1) ? `COEF_SINC1 :
                       (comp_mode_i == COMP_SINC3) ? `COEF_SINC3 : `COEF_BYPASS;

    logic [`SAMPLE_W-1:0] lane_out [NLANE];

    genvar g;
    generate
        for (g = 0; g < NLANE; g++) begin : g_lane
            logic signed [`MIX_W-1:0]    mix_r;
            logic signed [`CIC_IN_W-1:0] scl_r;
            logic signed [`CIC_W-1:0]    i1, i2, i3, d1, d2, d3;

            // mixer: round half up, then clip
            wire signed [`MIX_PROD_W:0] m_rnd = {mix_sum[g][`MIX_PROD_W-1], mix_sum[g]}
                                              + (`MIX_PROD_W+1)'(1 << (`MIX_DROP-1));
            wire signed [`MIX_PROD_W-`MIX_DROP:0] m_sh = m_rnd[`MIX_PROD_W:`MIX_DROP];
            wire m_pos = !m_sh[`MIX_PROD_W-`MIX_DROP] && |m_sh[`MIX_PROD_W-`MIX_DROP-1:`MIX_W-1];
            wire m_neg = m_sh[`MIX_PROD_W-`MIX_DROP] && !(&m_sh[`MIX_PROD_W-`MIX_DROP-1:`MIX_W-1]);
            wire signed [`MIX_W-1:0] m_sat = m_pos ? {1'b0, {(`MIX_W-1){1'b1}}} :
                                             m_neg ? {1'b1, {(`MIX_W-1){1'b0}}} :
                                             m_sh[`MIX_W-1:0];

            // agc and shifter; the lsb weight 2^-46 carries the fixed 2^-36 scaler
            wire signed [`SCL_PROD_W-1:0] s_prod = mix_r * $signed({1'b0, agc_mant});
            wire signed [`SCL_WIDE_W-1:0] s_wide = `SCL_WIDE_W'(s_prod) <<< gain_exp;
            wire signed [`SCL_WIDE_W-1:0] s_rnd  = s_wide + `SCL_WIDE_W'(1 << (`SCL_DROP-1));
            wire signed [`SCL_WIDE_W-1:0] s_sh   = s_rnd >>> `SCL_DROP;
            wire s_pos = !s_sh[`SCL_WIDE_W-1] && |s_sh[`SCL_WIDE_W-2:`CIC_IN_W-1];
            wire s_neg = s_sh[`SCL_WIDE_W-1] && !(&s_sh[`SCL_WIDE_W-2:`CIC_IN_W-1]);
            wire signed [`CIC_IN_W-1:0] s_sat = s_pos ? {1'b0, {(`CIC_IN_W-1){1'b1}}} :
                                                s_neg ? {1'b1, {(`CIC_IN_W-1){1'b0}}} :
                                                s_sh[`CIC_IN_W-1:0];

            // integrators at input rate, combs at the dump
            wire signed [`CIC_W-1:0] x_ext  = `CIC_W'(scl_r);
            wire signed [`CIC_W-1:0] n_i1   = i1 + x_ext;
            wire signed [`CIC_W-1:0] n_i2   = i2 + n_i1;
            wire signed [`CIC_W-1:0] n_i3   = i3 + n_i2;
            wire                     ord3   = (filt_mode_i == FILT_CIC3);
            wire signed [`CIC_W-1:0] c1     = (ord3 ? n_i3 : n_i1) - d1;
            wire signed [`CIC_W-1:0] c2     = c1 - d2;
            wire signed [`CIC_W-1:0] c3     = c2 - d3;
            wire signed [`CIC_W-1:0] cic_o  = (filt_mode_i == FILT_CIC3)     ? c3 :
                                              (filt_mode_i == FILT_INT_DUMP) ? c1 : x_ext;

            // round into the 2^1..2^-9 window
            wire signed [`CIC_W:0] c_rnd = {cic_o[`CIC_W-1], cic_o} + ((`CIC_W+1)'(1) <<< (`CIC_DROP-1));
            wire signed [`CIC_W-`CIC_DROP:0] c_sh = c_rnd[`CIC_W:`CIC_DROP];
            wire c_pos = !c_sh[`CIC_W-`CIC_DROP] && |c_sh[`CIC_W-`CIC_DROP-1:`CIC_OUT_W-1];
            wire c_neg = c_sh[`CIC_W-`CIC_DROP] && !(&c_sh[`CIC_W-`CIC_DROP-1:`CIC_OUT_W-1]);
            wire signed [`CIC_OUT_W-1:0] c_sat = c_pos ? {1'b0, {(`CIC_OUT_W-1){1'b1}}} :
                                                 c_neg ? {1'b1, {(`CIC_OUT_W-1){1'b0}}} :
                                                 c_sh[`CIC_OUT_W-1:0];

            // compensation gain, then round into 2^0..2^-9
            wire signed [`COMP_PROD_W-1:0] k_prod = c_sat * $signed({1'b0, comp_coef});
            wire signed [`COMP_PROD_W-1:0] k_rnd  = k_prod + `COMP_PROD_W'(1 << (`COMP_DROP-1));
            wire signed [`COMP_PROD_W-`COMP_DROP-1:0] k_sh = k_rnd[`COMP_PROD_W-1:`COMP_DROP];
            wire k_pos = !k_sh[`COMP_PROD_W-`COMP_DROP-1] && |k_sh[`COMP_PROD_W-`COMP_DROP-2:`SAMPLE_W-1];
            wire k_neg = k_sh[`COMP_PROD_W-`COMP_DROP-1] && !(&k_sh[`COMP_PROD_W-`COMP_DROP-2:`SAMPLE_W-1]);
            assign lane_out[g] = k_pos ? {1'b0, {(`SAMPLE_W-1){1'b1}}} :
                                 k_neg ? {1'b1, {(`SAMPLE_W-1){1'b0}}} :
                                 k_sh[`SAMPLE_W-1:0];

            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mix_r <= '0;
                    scl_r <= '0;
                end else if (adv) begin
                    mix_r <= m_sat;
                    scl_r <= s_sat;
                end
            end

            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    {i1, i2, i3, d1, d2, d3} <= '0;
                end else if (sample) begin
                    i1 <= n_i1;
                    i2 <= n_i2;
                    i3 <= n_i3;
                    if (dump_now) begin
                        d1 <= ord3 ? n_i3 : n_i1;
                        d2 <= c1;
                        d3 <= c2;
                    end
                end
            end
        end
    endgenerate

    iq_pair_s fifo_in;
    iq_pair_s head;
    logic     head_v;
    logic     pop;
    assign fifo_in = '{i: lane_out[0], q: lane_out[1]};

    sample_fifo #(
        .WIDTH ($bits(iq_pair_s)),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (head_v),
        .out_ready_i (pop),
        .out_data_o  (head)
    );

    wire                  parallel   = (cfg_i.out_mode == OUT_PARALLEL);
    wire                  interleave = (cfg_i.out_mode == OUT_SER_INTERLEAVED);
    wire [`SAMPLE_W-1:0]  fmt_i      = {head.i[`SAMPLE_W-1] ^ cfg_i.offset_binary, head.i[`SAMPLE_W-2:0]};
    wire [`SAMPLE_W-1:0]  fmt_q      = {head.q[`SAMPLE_W-1] ^ cfg_i.offset_binary, head.q[`SAMPLE_W-2:0]};
    // interleaved words: data on top, zero pad, tag in the i word lsb
    wire [`WORD_W-1:0]    word_i     = {fmt_i, {(`WORD_W-`SAMPLE_W-1){1'b0}}, interleave};
    wire [`WORD_W-1:0]    word_q     = {fmt_q, {(`WORD_W-`SAMPLE_W){1'b0}}};
    logic [`WORD_W-1:0]   rev_i;
    logic [`WORD_W-1:0]   rev_q;

    genvar b;
    generate
        for (b = 0; b < `WORD_W; b++) begin : g_rev
            assign rev_i[b] = word_i[`WORD_W-1-b];
            assign rev_q[b] = word_q[`WORD_W-1-b];
        end
    endgenerate

    // shifter sends bit 15 first; lsb-first loads a reversed word
    wire [`WORD_W-1:0] load_i = !cfg_i.lsb_first ? word_i :
                                interleave ? rev_i : {rev_i[`SAMPLE_W-1:0], {(`WORD_W-`SAMPLE_W){1'b0}}};
    wire [`WORD_W-1:0] load_q = !cfg_i.lsb_first ? word_q :
                                interleave ? rev_q : {rev_q[`SAMPLE_W-1:0], {(`WORD_W-`SAMPLE_W){1'b0}}};
    wire [`BITCNT_W-1:0] word_last = interleave ? `BITCNT_W'(`WORD_W-1) : `BITCNT_W'(`SAMPLE_W-1);

    // serial clock divider; data changes where the divided clock falls
    logic [`DIVCNT_W-1:0] div_cnt;
    logic [`DIVCNT_W-1:0] div_max;
    always_comb begin
        case (cfg_i.sclk_div)
            DIV_2:   div_max = `DIV_MAX_2;
            DIV_4:   div_max = `DIV_MAX_4;
            DIV_8:   div_max = `DIV_MAX_8;
            default: div_max = `DIV_MAX_1;
        endcase
    end
    wire bit_en   = (div_cnt >= div_max);
    wire sclk_pin = (cfg_i.sclk_div == DIV_1) || (div_cnt > (div_max >> 1));

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) div_cnt <= '0;
        else          div_cnt <= bit_en ? '0 : div_cnt + 1'b1;
    end

    fmt_state_e           state, next_state;
    logic [`WORD_W-1:0]   sh_i, next_sh_i;
    logic [`WORD_W-1:0]   sh_q, next_sh_q;
    logic [`BITCNT_W-1:0] bit_cnt, next_bit_cnt;
    logic                 q_pend, next_q_pend;
    logic [`SAMPLE_W-1:0] par_i, next_par_i;
    logic [`SAMPLE_W-1:0] par_q, next_par_q;
    logic                 par_stb, next_par_stb;

    always_comb begin
        next_state   = state;
        next_sh_i    = sh_i;
        next_sh_q    = sh_q;
        next_bit_cnt = bit_cnt;
        next_q_pend  = q_pend;
        next_par_i   = par_i;
        next_par_q   = par_q;
        next_par_stb = 1'b0;
        pop          = 1'b0;
        if (parallel) begin
            next_state = ST_IDLE;
            if (head_v) begin
                pop          = 1'b1;
                next_par_i   = fmt_i;
                next_par_q   = fmt_q;
                next_par_stb = 1'b1;
            end
        end else if (bit_en) begin
            case (state)
                ST_STROBE: begin
                    next_state = ST_SHIFT;
                end
                ST_SHIFT: begin
                    next_sh_i    = {sh_i[`WORD_W-2:0], 1'b0};
                    next_sh_q    = interleave ? sh_q : {sh_q[`WORD_W-2:0], 1'b0};
                    next_bit_cnt = bit_cnt - 1'b1;
                    if (bit_cnt == '0) begin
                        if (q_pend) begin
                            next_sh_i    = sh_q;
                            next_q_pend  = 1'b0;
                            next_bit_cnt = word_last;
                            next_state   = ST_STROBE;
                        end else if (head_v) begin
                            pop          = 1'b1;
                            next_sh_i    = load_i;
                            next_sh_q    = load_q;
                            next_q_pend  = interleave;
                            next_bit_cnt = word_last;
                            next_state   = ST_STROBE;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    if (head_v) begin
                        pop          = 1'b1;
                        next_sh_i    = load_i;
                        next_sh_q    = load_q;
                        next_q_pend  = interleave;
                        next_bit_cnt = word_last;
                        next_state   = ST_STROBE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state   <= ST_IDLE;
            sh_i    <= '0;
            sh_q    <= '0;
            bit_cnt <= '0;
            q_pend  <= 1'b0;
            par_i   <= '0;
            par_q   <= '0;
            par_stb <= 1'b0;
        end else begin
            state   <= next_state;
            sh_i    <= next_sh_i;
            sh_q    <= next_sh_q;
            bit_cnt <= next_bit_cnt;
            q_pend  <= next_q_pend;
            par_i   <= next_par_i;
            par_q   <= next_par_q;
            par_stb <= next_par_stb;
        end
    end

    wire shifting   = (state == ST_SHIFT);
    wire strobe_act = parallel ? par_stb : (state == ST_STROBE);

    assign output_valid_strobe_o = strobe_act ^ cfg_i.strobe_active_low;
    // serial: bit 0 data, i bus bit 9 divided clock, rest low
    assign inphase_out_bus_o    = parallel ? par_i :
                                  {sclk_pin, {(`SAMPLE_W-2){1'b0}}, shifting & sh_i[`WORD_W-1]};
    assign quadrature_out_bus_o = parallel ? par_q :
                                  {{(`SAMPLE_W-1){1'b0}}, shifting & !interleave & sh_q[`WORD_W-1]};
    // external logic may share the buses
    assign inphase_out_bus_oe_o    = {`SAMPLE_W{inphase_bus_enable_i}};
    assign quadrature_out_bus_oe_o = {`SAMPLE_W{quadrature_bus_enable_i}};

endmodule : baseband_gain_and_output_formatter

// *** pkg/bgof_defs.svh ***
// Purpose: numeric constants of the gain chain and output formatter
// Assumes: included by bare name, definitions only
// Notes:   weights noted as lsb weight of each stage
`ifndef BGOF_DEFS_SVH
`define BGOF_DEFS_SVH

`define SAMPLE_W     10
`define MIX_PROD_W   21
`define MIX_W        12
`define MIX_DROP     7
`define AGC_FRAC_W   4
`define AGC_EXP_W    3
`define SHIFT_W      6
`define GAIN_SUM_W   7
`define SCL_PROD_W   18
`define SCL_WIDE_W   96
`define SCL_DROP     5
`define CIC_IN_W     55
`define CIC_W        91
`define CIC_DROP     37
`define CIC_OUT_W    11
`define DEC_W        12
`define COEF_W       11
`define COEF_BYPASS  11'h400
`define COEF_SINC1   11'h29a
`define COEF_SINC3   11'h314
`define COMP_PROD_W  23
`define COMP_DROP    10
`define WORD_W       16
`define BITCNT_W     4
`define DIVCNT_W     3
`define DIV_MAX_1    3'h0
`define DIV_MAX_2    3'h1
`define DIV_MAX_4    3'h3
`define DIV_MAX_8    3'h7
`define FIFO_DEPTH   8

`endif

// *** pkg/bgof_pkg.sv ***
// Purpose: types shared by the gain chain and output formatter
// Assumes: nothing
// Notes:   enums carry no explicit codes
package bgof_pkg;

    typedef enum logic [1:0] {FILT_BYPASS, FILT_INT_DUMP, FILT_CIC3} filt_mode_e;
    typedef enum logic [1:0] {COMP_BYPASS, COMP_SINC1, COMP_SINC3} comp_mode_e;
    typedef enum logic [1:0] {OUT_PARALLEL, OUT_SER_SIMUL, OUT_SER_INTERLEAVED} out_mode_e;
    typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4, DIV_8} sclk_div_e;
    typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_SHIFT} fmt_state_e;

    typedef struct packed {
        logic [9:0] i;
        logic [9:0] q;
    } iq_pair_s;

    typedef struct packed {
        out_mode_e out_mode;
        logic      offset_binary;
        logic      strobe_active_low;
        logic      lsb_first;
        sclk_div_e sclk_div;
    } fmt_cfg_s;

endpackage : bgof_pkg

// *** verif/bgof_monitor.sv ***
// Purpose: pin checks for the output formatter
// Assumes: bound to the top module
// Notes:   cfg must sit still before clock checks
`timescale 1ns/1ps
module bgof_monitor import bgof_pkg::*; (
    input wire logic       clk_sys_i,             // clock
    input wire logic       rst_n_i,               // reset
    input wire fmt_cfg_s   cfg_i,                 // format
    input wire logic       inphase_bus_enable_i,  // i enable
    input wire logic [9:0] inphase_out_bus_o,     // i bus
    input wire logic [9:0] inphase_out_bus_oe_o,  // i drives
    input wire logic [9:0] quadrature_out_bus_o,  // q bus
    input wire logic       output_valid_strobe_o  // strobe
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire ser = cfg_i.out_mode != OUT_PARALLEL;
    wire act = output_valid_strobe_o ^ cfg_i.strobe_active_low;
    wire sck = inphase_out_bus_o[9];
    oe_follow_a: assert property (inphase_out_bus_oe_o == {10{inphase_bus_enable_i}})
        else $error("i enables wrong");
    pin_high_a: assert property ((ser && cfg_i.sclk_div == DIV_1 && $stable(cfg_i)) [*8] |-> sck)
        else $error("clock pin not high");
    div_two_a: assert property ((ser && cfg_i.sclk_div == DIV_2 && $stable(cfg_i)) [*8] |-> sck != $past(sck))
        else $error("clock not divided by 2");
    div_four_a: assert property ((ser && cfg_i.sclk_div == DIV_4 && $stable(cfg_i)) [*8] |-> sck != $past(sck, 2))
        else $error("clock not divided by 4");
    div_eight_a: assert property ((ser && cfg_i.sclk_div == DIV_8 && $stable(cfg_i)) [*8] |-> sck != $past(sck, 4))
        else $error("clock not divided by 8");
    strobe_span_a: assert property ($rose(act) && ser && cfg_i.sclk_div == DIV_2 && $stable(cfg_i) |=> act ##1 !act [*8])
        else $error("word strobe length wrong");
    pins_idle_a: assert property (ser && $stable(cfg_i) |-> inphase_out_bus_o[8:1] == 8'h00)
        else $error("unused i pins driven");
    q_quiet_a: assert property (cfg_i.out_mode == OUT_SER_INTERLEAVED && $stable(cfg_i) |-> quadrature_out_bus_o == 10'h000)
        else $error("q bus busy while interleaved");
endmodule : bgof_monitor

// *** verif/serial_receiver.sv ***
// Purpose: far-end receiver for the serial word formats
// Assumes: strobe arrives already at its active level
// Notes:   shifts msb first, so sent bit order shows in the word
`timescale 1ns/1ps
module serial_receiver (
    input  wire logic        clk_sys_i, // clock
    input  wire logic        rst_n_i,   // reset
    input  wire logic        sclk_i,    // serial clock pin
    input  wire logic        data_i,    // data line
    input  wire logic        strobe_i,  // word strobe
    input  wire logic        div1_i,    // bit clock is clk
    input  wire logic [4:0]  len_i,     // bits a word
    output      logic [15:0] word_o,    // last word
    output      logic [7:0]  count_o    // words seen
);
    logic       sclk_q;
    logic [4:0] left;
    // divide by one parks the pin high, so every clk carries a bit
    wire        take = div1_i | (sclk_i & ~sclk_q);
    wire [15:0] next_word = {word_o[14:0], data_i};
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q  <= 1'b0;
            left    <= 5'h00;
            word_o  <= 16'h0000;
            count_o <= 8'h00;
        end else begin
            sclk_q <= sclk_i;
            if (take && strobe_i) begin
                left   <= len_i;
                word_o <= 16'h0000;
            end else if (take && left != 5'h00) begin
                left    <= left - 5'h01;
                word_o  <= next_word;
                count_o <= count_o + {7'h00, left == 5'h01};
            end
        end
    end
endmodule : serial_receiver

// *** verif/tb_baseband_gain_and_output_formatter.sv ***
// Purpose: drives the gain chain and checks its formatted output
// Assumes: inputs move on the falling edge
// Notes:   every output saturates, so expectations stay exact
`timescale 1ns/1ps
module tb_baseband_gain_and_output_formatter import bgof_pkg::*; ;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, vld = 1'b1, ien = 1'b1;
    logic [9:0]  in_i = 10'h1ff;
    logic [6:0]  agc = 7'h7f;
    logic [11:0] dec = 12'h000;
    filt_mode_e  filt = FILT_BYPASS;
    comp_mode_e  comp = COMP_BYPASS;
    fmt_cfg_s    cfg = '{OUT_PARALLEL, 1'b0, 1'b0, 1'b0, DIV_2};
    wire         rdy, strb;
    wire  [9:0]  ib, qb, ioe, qoe;
    wire  [15:0] iw, qw;
    wire  [7:0]  ic;
    wire         act = strb ^ cfg.strobe_active_low;
    wire  [4:0]  len = (cfg.out_mode == OUT_SER_SIMUL) ? 5'h0a : 5'h10;
    int          failures = 0, num_checks = 0;
    out_mode_e   md[4] = '{OUT_SER_SIMUL, OUT_SER_SIMUL, OUT_SER_INTERLEAVED, OUT_SER_INTERLEAVED};
    sclk_div_e   dv[4] = '{DIV_2, DIV_1, DIV_4, DIV_8};
    logic [15:0] ea[4] = '{16'h01ff, 16'h03fe, 16'h7fc1, 16'h83fe}, eb[4] = '{16'h01ff, 16'h03fe, 16'h7fc0, 16'h03fe};
    baseband_gain_and_output_formatter baseband_gain_and_output_formatter_i (.clk_sys_i, .rst_n_i,
        .in_valid_i(vld), .in_ready_o(rdy), .in_i_i(in_i), .in_q_i(10'h000), .lo_cos_i(10'h1ff),
        .lo_sin_i(10'h1ff), .agc_frac_i(agc[3:0]), .agc_exp_i(agc[6:4]), .shift_i(6'h3f), .filt_mode_i(filt),
        .dec_div_i(dec), .comp_mode_i(comp), .cfg_i(cfg), .inphase_bus_enable_i(ien),
        .quadrature_bus_enable_i(1'b1), .inphase_out_bus_o(ib), .inphase_out_bus_oe_o(ioe),
        .quadrature_out_bus_o(qb), .quadrature_out_bus_oe_o(qoe), .output_valid_strobe_o(strb));
    serial_receiver serial_receiver_i (.clk_sys_i, .rst_n_i, .sclk_i(ib[9]), .data_i(ib[0]), .strobe_i(act),
        .div1_i(cfg.sclk_div == DIV_1), .len_i(len), .word_o(iw), .count_o(ic));
    serial_receiver serial_receiver_q_i (.clk_sys_i, .rst_n_i, .sclk_i(ib[9]), .data_i(qb[0]), .strobe_i(act),
        .div1_i(cfg.sclk_div == DIV_1), .len_i(len), .word_o(qw), .count_o());
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic hold(input int n);
        if (n >= 6000) begin
            failures++;
            stop_test();
        end
    endtask : hold
    task automatic par(input logic [9:0] ei, input logic [9:0] eq);
        int n;
        for (int s = 0; s < 8; s++) begin
            @(negedge clk_sys_i);
            for (n = 0; n < 6000 && act !== 1'b1; n++) @(negedge clk_sys_i);
            hold(n);
        end
        chk("i bus", 16'(ei), 16'(ib));
        chk("q bus", 16'(eq), 16'(qb));
    endtask : par
    task automatic rx(input logic [15:0] e, f, input logic sim);
        int n;
        logic [7:0] c;
        c = ic;
        for (n = 0; n < 6000 && !(ic != c && iw === e); n++) @(negedge clk_sys_i);
        hold(n);
        chk("i serial word", e, iw);
        c = ic;
        for (n = 0; n < 6000 && !sim && ic == c; n++) @(negedge clk_sys_i);
        hold(n);
        chk("q serial word", f, sim ? qw : iw);
    endtask : rx
    initial begin
        int n;
        repeat (12) @(negedge clk_sys_i);
        chk("ready in reset", 16'h0001, 16'(rdy));
        rst_n_i = 1'b1;
        par(10'h1ff, 10'h1ff);
        ien = 1'b0;
        @(negedge clk_sys_i);
        chk("i enables", 16'h0000, 16'(ioe));
        chk("q enables", 16'h03ff, 16'(qoe));
        ien = 1'b1;
        in_i = 10'h200;
        agc = 7'h00;
        filt = FILT_INT_DUMP;
        comp = COMP_SINC1;
        dec = 12'h003;
        cfg = '{OUT_PARALLEL, 1'b1, 1'b1, 1'b0, DIV_2};
        par(10'h000, 10'h000);
        in_i = 10'h1ff;
        filt = FILT_CIC3;
        comp = COMP_SINC3;
        for (int k = 0; k < 4; k++) begin
            cfg = '{md[k], 1'b0, 1'b0, k[0], dv[k]};
            rx(ea[k], eb[k], md[k] == OUT_SER_SIMUL);
        end
        for (n = 0; n < 6000 && rdy !== 1'b0; n++) @(negedge clk_sys_i);
        hold(n);
        chk("fifo full", 16'h0000, 16'(rdy));
        vld = 1'b0;
        for (n = 0; n < 6000 && rdy !== 1'b1; n++) @(negedge clk_sys_i);
        hold(n);
        chk("fifo drains", 16'h0001, 16'(rdy));
        stop_test();
    end
endmodule : tb_baseband_gain_and_output_formatter
bind baseband_gain_and_output_formatter bgof_monitor bgof_monitor_i (.*);
